// >>> hdl/dep_check_pkg.sv
// shared constants and types for the instruction group dependency checker
package dep_check_pkg;

    // ==========================================================
    // resource sizes
    localparam int GR_COUNT  = 128;
    localparam int PR_COUNT  = 64;
    localparam int BR_COUNT  = 8;
    localparam int AR_COUNT  = 4;
    localparam int POS_W     = 8;

    localparam logic [6:0]          STACKED_BASE = 7'h20;
    localparam int                  LOOP_PRED    = 63;
    localparam logic [GR_COUNT-1:0] GR_ONE       = 128'h1;
    localparam logic [PR_COUNT-1:0] USER_NAT_COLLECTION_REG_ONE     = 64'h1;
    localparam logic [PR_COUNT-1:0] PR_WRITABLE  = 64'hFFFF_FFFF_FFFF_FFFE;

    // implicit application resources, one bit each
    localparam int AR_LC  = 0;
    localparam int AR_EC  = 1;
    localparam int AR_PFS = 2;
    localparam int AR_CFM = 3;
    localparam logic [AR_COUNT-1:0] AR_LOOP_MASK = 4'h3;
    localparam logic [AR_COUNT-1:0] AR_CFM_MASK  = 4'h8;

    // ==========================================================
    // layout of the per-bit group records
    localparam int MK_GR_WR   = 0;
    localparam int MK_GR_CHK  = 128;
    localparam int MK_PR_WR   = 256;
    localparam int MK_PR_FP   = 320;
    localparam int MK_PR_NAND = 384;
    localparam int MK_PR_NOR  = 448;
    localparam int MK_SPILL   = 512;
    localparam int MK_W       = 576;

    // ==========================================================
    // register map (byte addresses)
    localparam logic [3:0]  ADDR_CTRL   = 4'h0;
    localparam logic [3:0]  ADDR_STATUS = 4'h4;
    localparam logic [3:0]  ADDR_FSTAT  = 4'h8;
    localparam int          CTRL_EN_BIT = 0;
    localparam logic        CTRL_EN_RST = 1'b1;

    // ==========================================================
    // enumerations
    typedef enum logic [3:0] {
        CLS_OTHER, CLS_FP, CLS_BRANCH, CLS_RESIZE, CLS_CHK_LOAD,
        CLS_SPILL, CLS_FILL, CLS_MOV_TO_USER_NAT_COLLECTION_REG, CLS_MOV_FROM_USER_NAT_COLLECTION_REG,
        CLS_MOV_TO_PR, CLS_MOV_FROM_PR
    } ins_class_e;

    typedef enum logic [1:0] {BR_PLAIN, BR_COUNTED, BR_MODULO} br_kind_e;
    typedef enum logic [1:0] {CMP_PLAIN, CMP_AND, CMP_OR} cmp_e;
    typedef enum logic [2:0] {FLT_NONE, FLT_RAW, FLT_WAW, FLT_WAR, FLT_PLACE} fault_e;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic [5:0] float_status_reg;
        logic [3:0] processor_status_reg;
    } status_s;

    typedef struct packed {
        logic                 valid;
        logic                 entry;
        logic                 flow_taken;
        logic                 stop;
        logic                 br_taken;
        logic                 brk_fault;
        logic                 resv_fault;
        ins_class_e           cls;
        br_kind_e             br_kind;
        cmp_e                 cmp;
        logic                 qp;
        logic [1:0]           gr_rd_en;
        logic [6:0]           gr_rd0;
        logic [6:0]           gr_rd1;
        logic                 gr_wr_en;
        logic [6:0]           gr_wr;
        logic [PR_COUNT-1:0]  pr_rd;
        logic [PR_COUNT-1:0]  pr_wr;
        logic [BR_COUNT-1:0]  br_rd;
        logic [BR_COUNT-1:0]  br_wr;
        logic [AR_COUNT-1:0]  ar_rd;
        logic [AR_COUNT-1:0]  ar_wr;
        logic [5:0]           user_nat_collection_reg_bit;
        logic                 bad_after_resize;
        status_s              fp_status;
    } insn_s;

    typedef struct packed {
        logic             valid;
        fault_e           kind;
        logic [POS_W-1:0] pos;
    } fault_s;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } wb_req_s;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } wb_rsp_s;

endpackage

// >>> hdl/bit_mark.sv
// per-bit sticky records of one instruction group
module bit_mark #(
    parameter int WIDTH = 576
) (
    input  wire logic             i_clk,     // core clock
    input  wire logic             i_rst,     // synchronous reset, high
    input  wire logic             i_restart, // drop old marks, keep this set
    input  wire logic             i_flush,   // drop all marks
    input  wire logic [WIDTH-1:0] i_set,     // marks of this instruction
    output logic      [WIDTH-1:0] o_mark     // marks so far
);
    typedef struct packed {
        logic [WIDTH-1:0] mark;
    } state_s;

    state_s           st;
    state_s           next_st;
    logic [WIDTH-1:0] next_bits;

    // ==========================================================
    // one sticky bit per resource
    for (genvar b = 0; b < WIDTH; b++) begin : g_bit
        assign next_bits[b] = !i_flush && ((!i_restart && st.mark[b]) || i_set[b]);
    end

    always_comb begin
        next_st      = st;
        next_st.mark = next_bits;
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_mark = st.mark;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    flush_clears_a: assert property (i_flush |=> o_mark == '0)
        else $error("marks survive a group flush");
endmodule

// >>> hdl/status_merge.sv
// merges floating-point status writes of one group by OR
module status_merge (
    input  wire logic                   i_clk,    // core clock
    input  wire logic                   i_rst,    // synchronous reset, high
    input  wire dep_check_pkg::status_s i_set,    // status bits written now
    input  wire logic                   i_commit, // group ends with this one
    output dep_check_pkg::status_s      o_status  // committed status
);
    import dep_check_pkg::*;

    typedef struct packed {
        status_s acc;
        status_s committed;
    } state_s;

    state_s st;
    state_s next_st;

    // ==========================================================
    // accumulate inside the group, fold in at its end
    always_comb begin
        next_st = st;
        if (i_commit) begin
            next_st.committed = st.committed | st.acc | i_set;
            next_st.acc       = '0;
        end else begin
            next_st.acc = st.acc | i_set;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_status = st.committed;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    or_merge_a: assert property (i_commit |=> o_status == ($past(o_status) | $past(st.acc) | $past(i_set)))
        else $error("group status is not the OR of its writes");
endmodule

// >>> hdl/dep_checker.sv
// instruction group dependency checker with illegal-dependency fault reporting
module dep_checker (
    input  wire logic                   I_SYS_CLK,        // core clock, 125 MHz
    input  wire logic                   I_RST,            // synchronous reset, high
    input  wire dep_check_pkg::insn_s   I_INSN,           // decoded instruction, in order
    input  wire dep_check_pkg::wb_req_s I_WB,             // wishbone request
    output dep_check_pkg::wb_rsp_s      O_WB,             // wishbone answer
    output dep_check_pkg::fault_s       O_FAULT,          // illegal-dependency fault
    output dep_check_pkg::status_s      O_FLOAT_STATUS    // merged float status
);
    import dep_check_pkg::*;

    typedef struct packed {
        logic [POS_W-1:0]    pos;
        logic                resize_seen;
        logic [BR_COUNT-1:0] br_wr;
        logic [BR_COUNT-1:0] br_by_br;
        logic [AR_COUNT-1:0] ar_wr;
        logic [AR_COUNT-1:0] ar_by_br;
        logic                p63_rd;
        logic                user_nat_collection_reg_ar_wr;
        logic                det_en;
        logic [15:0]         fault_cnt;
        fault_s              fault;
        wb_rsp_s             wb;
    } state_s;

    function automatic state_s drop_group(input state_s s);
        state_s r;
        r             = s;
        r.pos         = '0;
        r.resize_seen = 1'b0;
        r.br_wr       = '0;
        r.br_by_br    = '0;
        r.ar_wr       = '0;
        r.ar_by_br    = '0;
        r.p63_rd      = 1'b0;
        r.user_nat_collection_reg_ar_wr  = 1'b0;
        return r;
    endfunction

    state_s              st;
    state_s              next_st;
    state_s              cur;
    logic                restart;
    logic                group_end;
    logic                is_br;
    logic                act;
    logic                fire;
    logic                raw_hit;
    logic                waw_hit;
    logic                war_hit;
    logic                place_hit;
    logic                stacked_acc;
    logic                wb_hit;
    logic [MK_W-1:0]     mark;
    logic [MK_W-1:0]     view;
    logic [MK_W-1:0]     mark_set;
    logic [GR_COUNT-1:0] gr_rd_vec;
    logic [GR_COUNT-1:0] gr_wr_vec;
    logic [PR_COUNT-1:0] pr_rd_eff;
    logic [PR_COUNT-1:0] pr_wr_eff;
    logic [PR_COUNT-1:0] pr_ok;
    logic [PR_COUNT-1:0] user_nat_collection_reg_vec;
    logic [PR_COUNT-1:0] v_pr_wr;
    logic [PR_COUNT-1:0] v_pr_fp;
    logic [PR_COUNT-1:0] v_spill;
    logic [GR_COUNT-1:0] v_gr_wr;
    logic [GR_COUNT-1:0] v_gr_chk;
    logic                user_nat_collection_reg_raw;
    logic                user_nat_collection_reg_waw;
    status_s             fp_set;

    // ==========================================================
    // group framing
    assign restart   = I_INSN.valid && (I_INSN.entry || I_INSN.flow_taken);
    assign group_end = I_INSN.stop || I_INSN.br_taken
                       || I_INSN.brk_fault || I_INSN.resv_fault;
    assign cur       = restart ? drop_group(st) : st;
    assign view      = restart ? '0 : mark;
    assign is_br     = I_INSN.cls == CLS_BRANCH;
    // plain branches with a false predicate vanish, loop branches never do
    assign act       = I_INSN.valid && (I_INSN.qp
                       || (is_br && I_INSN.br_kind != BR_PLAIN));

    assign v_gr_wr  = view[MK_GR_WR +: GR_COUNT];
    assign v_gr_chk = view[MK_GR_CHK +: GR_COUNT];
    assign v_pr_wr  = view[MK_PR_WR +: PR_COUNT];
    assign v_pr_fp  = view[MK_PR_FP +: PR_COUNT];
    assign v_spill  = view[MK_SPILL +: PR_COUNT];

    // ==========================================================
    // operand decode
    assign gr_rd_vec = (I_INSN.gr_rd_en[0] ? (GR_ONE << I_INSN.gr_rd0) : '0)
                       | (I_INSN.gr_rd_en[1] ? (GR_ONE << I_INSN.gr_rd1) : '0);
    assign gr_wr_vec = I_INSN.gr_wr_en ? (GR_ONE << I_INSN.gr_wr) : '0;
    assign stacked_acc = (I_INSN.gr_rd_en[0] && I_INSN.gr_rd0 >= STACKED_BASE)
                         || (I_INSN.gr_rd_en[1] && I_INSN.gr_rd1 >= STACKED_BASE)
                         || (I_INSN.gr_wr_en && I_INSN.gr_wr >= STACKED_BASE);
    assign pr_rd_eff = ((I_INSN.cls == CLS_MOV_FROM_PR) ? '1 : I_INSN.pr_rd)
                       & PR_WRITABLE;
    assign pr_wr_eff = I_INSN.pr_wr & PR_WRITABLE;
    assign pr_ok     = (I_INSN.cmp == CMP_AND) ? ~view[MK_PR_NAND +: PR_COUNT]
                     : (I_INSN.cmp == CMP_OR)  ? ~view[MK_PR_NOR +: PR_COUNT] : '0;
    assign user_nat_collection_reg_vec  = USER_NAT_COLLECTION_REG_ONE << I_INSN.user_nat_collection_reg_bit;

    // ==========================================================
    // collection register, checked per bit for spill and fill
    assign user_nat_collection_reg_raw = (I_INSN.cls == CLS_FILL && (|(user_nat_collection_reg_vec & v_spill) || cur.user_nat_collection_reg_ar_wr))
                      || (I_INSN.cls == CLS_MOV_FROM_USER_NAT_COLLECTION_REG
                          && (|v_spill || cur.user_nat_collection_reg_ar_wr));
    assign user_nat_collection_reg_waw = (I_INSN.cls == CLS_SPILL && (|(user_nat_collection_reg_vec & v_spill) || cur.user_nat_collection_reg_ar_wr))
                      || (I_INSN.cls == CLS_MOV_TO_USER_NAT_COLLECTION_REG && (|v_spill || cur.user_nat_collection_reg_ar_wr));

    // ==========================================================
    // hazard classes, blamed on the current (second) instruction
    assign raw_hit = |(gr_rd_vec & v_gr_wr & ~v_gr_chk)
                     || |(pr_rd_eff & v_pr_wr & (is_br ? v_pr_fp : '1))
                     || |(I_INSN.br_rd & cur.br_wr & (is_br ? cur.br_by_br : '1))
                     || |(I_INSN.ar_rd & cur.ar_wr
                          & (is_br ? (AR_LOOP_MASK | cur.ar_by_br) : '1))
                     || (stacked_acc && cur.ar_by_br[AR_CFM])
                     || user_nat_collection_reg_raw;
    assign waw_hit = |(gr_wr_vec & v_gr_wr)
                     || |(pr_wr_eff & v_pr_wr & ~pr_ok)
                     || |(I_INSN.br_wr & cur.br_wr)
                     || |(I_INSN.ar_wr & cur.ar_wr)
                     || user_nat_collection_reg_waw;
    assign war_hit = is_br && I_INSN.br_kind == BR_MODULO
                     && pr_wr_eff[LOOP_PRED] && cur.p63_rd;
    assign place_hit = (I_INSN.cls == CLS_RESIZE && cur.pos != '0)
                       || (I_INSN.bad_after_resize && cur.resize_seen);
    assign fire = st.det_en && act && (raw_hit || waw_hit || war_hit || place_hit);

    // ==========================================================
    // marks left by this instruction; float status has no WAW check
    assign mark_set = (act && !fire) ? {
        (I_INSN.cls == CLS_SPILL) ? user_nat_collection_reg_vec : '0,
        (I_INSN.cmp != CMP_OR)    ? pr_wr_eff : '0,
        (I_INSN.cmp != CMP_AND)   ? pr_wr_eff : '0,
        (I_INSN.cls == CLS_FP)    ? pr_wr_eff : '0,
        pr_wr_eff,
        (I_INSN.cls == CLS_CHK_LOAD) ? gr_wr_vec : '0,
        gr_wr_vec
    } : '0;

    assign fp_set = (act && I_INSN.cls == CLS_FP) ? I_INSN.fp_status : '0;

    bit_mark #(
        .WIDTH (MK_W)
    ) u_marks (
        .i_clk     (I_SYS_CLK),
        .i_rst     (I_RST),
        .i_restart (restart),
        .i_flush   (I_INSN.valid && (group_end || fire)),
        .i_set     (mark_set),
        .o_mark    (mark)
    );

    status_merge u_status (
        .i_clk    (I_SYS_CLK),
        .i_rst    (I_RST),
        .i_set    (fp_set),
        .i_commit (I_INSN.valid && group_end),
        .o_status (O_FLOAT_STATUS)
    );

    // ==========================================================
    // register bus and group state
    assign wb_hit = I_WB.cyc && I_WB.stb && !st.wb.ack;

    always_comb begin
        next_st             = cur;
        next_st.fault.valid = 1'b0;
        next_st.wb.ack      = wb_hit;
        next_st.wb.dat      = '0;
        if (wb_hit && !I_WB.we) begin
            case (I_WB.adr)
                ADDR_CTRL:   next_st.wb.dat = {31'h0, st.det_en};
                ADDR_STATUS: next_st.wb.dat = {st.fault_cnt, 5'h00, st.fault.kind, st.fault.pos};
                ADDR_FSTAT:  next_st.wb.dat = {22'h0, O_FLOAT_STATUS};
                default:     next_st.wb.dat = '0;
            endcase
        end
        if (wb_hit && I_WB.we && I_WB.adr == ADDR_CTRL && I_WB.sel[0]) begin
            next_st.det_en = I_WB.dat[CTRL_EN_BIT];
        end
        if (wb_hit && I_WB.we && I_WB.adr == ADDR_STATUS) begin
            next_st.fault_cnt = '0;
        end
        if (I_INSN.valid) begin
            next_st.pos = POS_W'(cur.pos + 8'h01);
            if (fire) begin
                next_st.fault.valid = 1'b1;
                next_st.fault.pos   = cur.pos;
                next_st.fault.kind  = raw_hit ? FLT_RAW : waw_hit ? FLT_WAW
                                    : war_hit ? FLT_WAR : FLT_PLACE;
                // count set wins over a same-cycle clear
                next_st.fault_cnt   = 16'(next_st.fault_cnt + 16'h0001);
            end else if (act) begin
                next_st.resize_seen = cur.resize_seen || I_INSN.cls == CLS_RESIZE;
                next_st.br_wr       = cur.br_wr | I_INSN.br_wr;
                next_st.br_by_br    = cur.br_by_br | (is_br ? I_INSN.br_wr : '0);
                next_st.ar_wr       = cur.ar_wr | I_INSN.ar_wr
                                    | ((I_INSN.cls == CLS_RESIZE) ? AR_CFM_MASK : '0);
                next_st.ar_by_br    = cur.ar_by_br | (is_br ? I_INSN.ar_wr : '0);
                next_st.p63_rd      = cur.p63_rd || (is_br && pr_rd_eff[LOOP_PRED]);
                next_st.user_nat_collection_reg_ar_wr  = cur.user_nat_collection_reg_ar_wr || I_INSN.cls == CLS_MOV_TO_USER_NAT_COLLECTION_REG;
            end
            if (group_end || fire) begin
                next_st = drop_group(next_st);
            end
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            st        <= '0;
            st.det_en <= CTRL_EN_RST;
        end else begin
            st <= next_st;
        end
    end

    assign O_WB    = st.wb;
    assign O_FAULT = st.fault;

    // ==========================================================
    // checks
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (I_RST);

    group_flush_a: assert property (I_INSN.valid && group_end |=> st.pos == '0)
        else $error("records kept across a group boundary");
    pred_off_a: assert property (I_INSN.valid && !I_INSN.qp && !is_br |=> !O_FAULT.valid)
        else $error("predicated-off instruction faulted");
    loop_counter_a: assert property (st.det_en && act && is_br && I_INSN.br_kind != BR_PLAIN
        && |(I_INSN.ar_rd & cur.ar_wr & AR_LOOP_MASK)
        |=> O_FAULT.valid && O_FAULT.kind == FLT_RAW)
        else $error("loop branch counter RAW missed");
    fp_pred_a: assert property (st.det_en && act && is_br && |(pr_rd_eff & v_pr_fp)
        |=> O_FAULT.valid && O_FAULT.kind == FLT_RAW)
        else $error("branch read of float-written predicate missed");
    cmp_waw_a: assert property (st.det_en && act && !raw_hit && I_INSN.cmp == CMP_PLAIN
        && |(pr_wr_eff & v_pr_wr) |=> O_FAULT.valid && O_FAULT.kind == FLT_WAW)
        else $error("plain compare WAW on predicate missed");
    fill_bit_a: assert property (st.det_en && act && I_INSN.cls == CLS_FILL
        && |(user_nat_collection_reg_vec & v_spill) |=> O_FAULT.kind == FLT_RAW && O_FAULT.valid)
        else $error("fill of spilled collection bit missed");
    spill_move_a: assert property (st.det_en && act && !raw_hit && I_INSN.cls == CLS_SPILL
        && cur.user_nat_collection_reg_ar_wr |=> O_FAULT.valid && O_FAULT.kind == FLT_WAW)
        else $error("spill after collection move missed");
    war_pos_a: assert property (st.det_en && act && war_hit && !raw_hit && !waw_hit
        |=> O_FAULT.kind == FLT_WAR && O_FAULT.pos == $past(cur.pos))
        else $error("p63 WAR not blamed on the writer");
    det_off_a: assert property (!st.det_en |=> !O_FAULT.valid)
        else $error("fault raised with detection off");
    fault_order_a: assert property (O_FAULT.valid |-> st.pos == '0 ##1 !O_FAULT.valid)
        else $error("group survived a delivered fault");
    entry_a: assert property (I_INSN.valid && I_INSN.entry && !group_end && !fire
        |=> st.pos == 8'h01)
        else $error("entry point did not restart the group");
    wb_ack_a: assert property (wb_hit |=> O_WB.ack ##1 !O_WB.ack)
        else $error("bus answer not a single cycle");

    raw_seen_c: cover property (O_FAULT.valid && O_FAULT.kind == FLT_RAW);
    waw_seen_c: cover property (O_FAULT.valid && O_FAULT.kind == FLT_WAW);
    war_seen_c: cover property (O_FAULT.valid && O_FAULT.kind == FLT_WAR);
    merge_seen_c: cover property (act && I_INSN.cls == CLS_FP ##2 act && I_INSN.cls == CLS_FP);
endmodule

// >>> testbench/insn_source.sv
// instruction stream source standing in for compiled software
module insn_source
    import dep_check_pkg::*;
(
    input  wire logic i_clk,  // core clock
    output insn_s     o_insn  // issued instruction
);
    timeunit 1ns;
    timeprecision 1ps;
    initial o_insn = '0;
    // one insn per call, then an idle cycle with scrambled fields
    task automatic issue(input insn_s x);
        o_insn <= x;
        @(posedge i_clk);
        o_insn <= {1'b0, ~x[$bits(insn_s)-2:0]};
        @(posedge i_clk);
    endtask
endmodule

// >>> testbench/dep_checker_tb_top.sv
// self-checking bench for the dependency checker
module dep_checker_tb_top;
    import dep_check_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic    clk         = 1'b0;
    logic    rst         = 1'b1;
    insn_s   insn;
    wb_req_s wb_req      = '0;
    wb_rsp_s wb_rsp;
    fault_s  fault;
    status_s fstat;
    int      err_total   = 0;
    int      comparisons = 0;
    int      nflt        = 0;
    int      tid         = 0;
    initial forever #4 clk = ~clk;
    insn_source insn_source_i (.i_clk(clk), .o_insn(insn));
    dep_checker dep_checker_i (.I_SYS_CLK(clk), .I_RST(rst), .I_INSN(insn), .I_WB(wb_req),
        .O_WB(wb_rsp), .O_FAULT(fault), .O_FLOAT_STATUS(fstat));
    always @(posedge clk) if (fault.valid === 1'b1) nflt <= nflt + 1;
    task automatic report_and_stop;
        $display("comparisons=%0d mismatches=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] wd,
                      output logic [31:0] rd);
        int n;
        wb_req <= '{1'b1, 1'b1, we, adr, 4'hF, wd};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wb_rsp.ack !== 1'b1 && n < 50);
        rd = wb_rsp.dat;
        wb_req <= '0;
        @(posedge clk);
        if (n >= 50) begin
            err_total++;
            report_and_stop();
        end
    endtask
    function automatic insn_s base(input ins_class_e c);
        base = '0;
        base.valid = 1'b1;
        base.qp = 1'b1;
        base.cls = c;
    endfunction
    // two insns, then fault count and last kind/pos
    task automatic pair(input insn_s a, input insn_s b, input int d, input logic [2:0] k,
                        input logic [7:0] p);
        int n0;
        n0 = nflt;
        b.stop = 1'b1;
        insn_source_i.issue(a);
        insn_source_i.issue(b);
        @(posedge clk);
        cmp(nflt - n0, d);
        cmp(fault.kind, k);
        cmp(fault.pos, p);
        $display("test %0d done", tid++);
    endtask
    initial begin
        logic [31:0] r;
        insn_s a, b, c;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        a = base(CLS_OTHER);
        a.gr_wr_en = 1'b1;
        a.gr_wr = 7'h05;
        b = base(CLS_OTHER);
        b.gr_rd_en = 2'h1;
        b.gr_rd0 = 7'h05;
        pair(a, b, 1, FLT_RAW, 8'h01);
        c = b;
        c.entry = 1'b1;
        pair(a, c, 0, FLT_RAW, 8'h01);
        c.entry = 1'b0;
        c.flow_taken = 1'b1;
        pair(a, c, 0, FLT_RAW, 8'h01);
        wb(1'b1, ADDR_CTRL, 32'h0, r);
        pair(a, b, 0, FLT_RAW, 8'h01);
        wb(1'b1, ADDR_CTRL, 32'h1, r);
        wb(1'b0, ADDR_STATUS, 32'h0, r);
        cmp(r, {16'h0001, 5'h00, FLT_RAW, 8'h01});
        wb(1'b0, 4'hC, 32'h0, r);
        cmp(r, 32'h0);
        a.stop = 1'b1;
        pair(a, b, 0, FLT_RAW, 8'h01);
        a = base(CLS_BRANCH);
        a.qp = 1'b0;
        a.br_wr = 8'h01;
        b = base(CLS_OTHER);
        b.br_rd = 8'h01;
        pair(a, b, 0, FLT_RAW, 8'h01);
        a.br_kind = BR_COUNTED;
        pair(a, b, 1, FLT_RAW, 8'h01);
        a = base(CLS_OTHER);
        a.ar_wr = 4'h4;
        b = base(CLS_BRANCH);
        b.ar_rd = 4'h4;
        pair(a, b, 0, FLT_RAW, 8'h01);
        a.ar_wr = 4'h1;
        b.ar_rd = 4'h1;
        b.br_kind = BR_COUNTED;
        pair(a, b, 1, FLT_RAW, 8'h01);
        a = base(CLS_OTHER);
        a.pr_wr = 64'h20;
        b.pr_rd = 64'h20;
        pair(a, b, 0, FLT_RAW, 8'h01);
        a.cls = CLS_FP;
        pair(a, b, 1, FLT_RAW, 8'h01);
        a.cls = CLS_OTHER;
        a.cmp = CMP_AND;
        b = a;
        pair(a, b, 0, FLT_RAW, 8'h01);
        a.cmp = CMP_PLAIN;
        b.cmp = CMP_OR;
        pair(a, b, 1, FLT_WAW, 8'h01);
        a.pr_wr = 64'h1;
        b.pr_wr = 64'h1;
        pair(a, b, 0, FLT_WAW, 8'h01);
        a = base(CLS_SPILL);
        a.user_nat_collection_reg_bit = 6'h03;
        b = a;
        b.user_nat_collection_reg_bit = 6'h04;
        pair(a, b, 0, FLT_WAW, 8'h01);
        b.user_nat_collection_reg_bit = 6'h03;
        pair(a, b, 1, FLT_WAW, 8'h01);
        b.cls = CLS_FILL;
        pair(a, b, 1, FLT_RAW, 8'h01);
        a = base(CLS_FP);
        a.fp_status = 10'h010;
        b = a;
        b.fp_status = 10'h021;
        pair(a, b, 0, FLT_RAW, 8'h01);
        cmp(fstat, 10'h031);
        b = base(CLS_RESIZE);
        pair(base(CLS_OTHER), b, 1, FLT_PLACE, 8'h01);
        a = base(CLS_CHK_LOAD);
        a.gr_wr_en = 1'b1;
        a.gr_wr = 7'h05;
        b = base(CLS_OTHER);
        b.gr_rd_en = 2'h1;
        b.gr_rd0 = 7'h05;
        pair(a, b, 0, FLT_PLACE, 8'h01);
        a = base(CLS_OTHER);
        a.pr_wr = 64'h100;
        pair(a, base(CLS_MOV_FROM_PR), 1, FLT_RAW, 8'h01);
        a = base(CLS_RESIZE);
        b.gr_rd0 = 7'h20;
        pair(a, b, 0, FLT_RAW, 8'h01);
        c = base(CLS_OTHER);
        c.bad_after_resize = 1'b1;
        pair(a, c, 1, FLT_PLACE, 8'h01);
        a = base(CLS_MOV_TO_USER_NAT_COLLECTION_REG);
        b = base(CLS_SPILL);
        b.user_nat_collection_reg_bit = 6'h03;
        pair(a, b, 1, FLT_WAW, 8'h01);
        a = base(CLS_BRANCH);
        a.pr_rd = 64'h8000_0000_0000_0000;
        b = base(CLS_BRANCH);
        b.br_kind = BR_MODULO;
        b.pr_wr = a.pr_rd;
        pair(a, b, 1, FLT_WAR, 8'h01);
        wb(1'b0, ADDR_CTRL, 32'h0, r);
        cmp(r, 32'h1);
        wb(1'b0, ADDR_FSTAT, 32'h0, r);
        cmp(r, 32'h31);
        report_and_stop();
    end
endmodule
